// ### hdl/mpt_pkg.sv
package mpt_pkg;

  // ****************************************************
  // Register map (register indices, and the byte addresses of the slave port made from them)
  // ****************************************************
  localparam logic [7:0] PIN_CTRL_INDEX  = 8'h63;
  localparam logic [7:0] IRQ_FLAGS_INDEX = 8'h60;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h70;
  localparam logic [7:0] IRQ_MASK_ADDR   = 8'h71;
  localparam logic [9:0] PIN_CTRL_ADDR   = {PIN_CTRL_INDEX, 2'b00};
  localparam logic [9:0] IRQ_FLAGS_ADDR  = {IRQ_FLAGS_INDEX, 2'b00};
  localparam logic [9:0] STATUS_ADDR     = {IRQ_STATUS_ADDR, 2'b00};
  localparam logic [9:0] MASK_ADDR       = {IRQ_MASK_ADDR, 2'b00};

  // ****************************************************
  // Field positions and reset values
  // ****************************************************
  localparam int          FUNC_MSB        = 7;
  localparam int          FUNC_LSB        = 4;
  localparam int          OUT_VAL_BIT     = 3;
  localparam int          IN_VAL_BIT      = 2;
  localparam int          DUR_BIT         = 1;
  localparam logic [3:0]  FUNC_RESET      = 4'h0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'hfa;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

  // Sticky event bits
  localparam int          EV_HEADSET      = 0;
  localparam int          EV_BUTTON       = 1;
  localparam int          EV_SHORT        = 2;
  localparam int          EV_NOISE        = 3;
  localparam int          EV_PIN_IN       = 4;
  localparam int          EV_W            = 5;

  // ****************************************************
  // Function codes
  // ****************************************************
  localparam logic [3:0] FN_OFF        = 4'h0;
  localparam logic [3:0] FN_RSVD       = 4'h1;
  localparam logic [3:0] FN_HEADSET    = 4'h2;
  localparam logic [3:0] FN_GP_IN      = 4'h3;
  localparam logic [3:0] FN_GP_OUT     = 4'h4;
  localparam logic [3:0] FN_MIC_LO     = 4'h5;
  localparam logic [3:0] FN_MIC_HI     = 4'h7;
  localparam logic [3:0] FN_BIT_CLK    = 4'h8;
  localparam logic [3:0] FN_HS_BTN     = 4'h9;
  localparam logic [3:0] FN_ALL4       = 4'ha;
  localparam logic [3:0] FN_SC_NG      = 4'hb;
  localparam logic [3:0] FN_HS_BTN_SC  = 4'hc;
  localparam logic [3:0] FN_SHORT      = 4'hd;
  localparam logic [3:0] FN_NOISE      = 4'he;
  localparam logic [3:0] FN_BUTTON     = 4'hf;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_MHZ        = 200;
  localparam int HEADSET_US     = 1750;
  localparam int PULSE_US       = 2000;
  localparam int GAP_US         = 2000;
  localparam int HEADSET_CYCLES = HEADSET_US * CLK_MHZ;
  localparam int PULSE_CYCLES   = PULSE_US * CLK_MHZ;
  localparam int GAP_CYCLES     = GAP_US * CLK_MHZ;
  localparam int CNT_W          = 20;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_HIGH,
    PS_GAP
  } mpt_pulse_state_t;

endpackage : mpt_pkg

// ### hdl/mpt_pin_two.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
// Function
// [R1] Function field resets to zero, pin idle
// [R2] Host never writes reserved code 0001
// [R3] Code 0010: headset interrupt, 1.75 ms high
// [R4] Code 0011: pin undriven, sampled as input
// [R5] Input value bit shows pin level
// [R6] Code 0100: pin driven as output
// [R7] Output level follows bit 3
// [R8] Codes 0101-0111: microphone data input
// [R9] Code 1000: bit clock, direction per bus
// [R10] Code 1001: headset OR button
// [R11] Code 1010: OR of all four
// [R12] Code 1011: short OR noise gate
// [R13] Code 1100: headset, button, short ORed
// [R14] Code 1101: short circuit alone
// [R15] Code 1111: button alone
// [R16] Code 1110: noise gate alone
// [R17] Duration bit clear: one 2 ms pulse
// [R18] Duration bit set: pulse until flags read
// [R19] Host writes zero to bit 0
module mpt_pin_two
  import mpt_pkg::*;
#(
  parameter int HEADSET_CNT = HEADSET_CYCLES,
  parameter int PULSE_CNT   = PULSE_CYCLES,
  parameter int GAP_CNT     = GAP_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Detection events, one-cycle pulses
  input  wire logic        headset_event,
  input  wire logic        button_event,
  input  wire logic        short_event,
  input  wire logic        noise_event,
  // Audio bus bit clock
  input  wire logic        bit_clk_master,
  input  wire logic        bit_clk_out,
  output logic             bit_clk_in,
  // Microphone data and clock
  input  wire logic        mic_clk,
  output logic             mic_data_rise,
  output logic             mic_data_fall,
  // Pin
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe,
  // Interrupt
  output logic             irq
);

  // ****************************************************
  // Registers and bus
  // ****************************************************
  logic [3:0]       func;
  logic             out_val;
  logic             in_val;
  logic             dur_cont;
  logic [EV_W-1:0]  status;
  logic [EV_W-1:0]  mask;
  logic             ack;
  logic             in_prev;
  logic             mic_prev;
  logic             flags_read;
  logic             sel_event;
  logic             sel_level;
  logic [EV_W-1:0]  ev_set;
  mpt_pulse_state_t state;
  logic [CNT_W-1:0] cnt;
  logic             pulse_hold;
  logic             is_input;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = (a == r);
  endfunction : hit

  // One wait state: every access answers on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign flags_read = avs_read & ack & hit(avs_address, IRQ_FLAGS_ADDR);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      func     <= FUNC_RESET; // [R1]
      out_val  <= 1'b0;
      dur_cont <= 1'b0;
      mask     <= '0;
    end else if (avs_write && ack && avs_byteenable[0]) begin
      if (hit(avs_address, PIN_CTRL_ADDR)) begin
        // Bit 0 is not stored, so a stray one does no harm
        func     <= avs_writedata[FUNC_MSB:FUNC_LSB];
        out_val  <= avs_writedata[OUT_VAL_BIT]; // [R7]
        dur_cont <= avs_writedata[DUR_BIT];
      end
      if (hit(avs_address, MASK_ADDR)) begin
        mask <= avs_writedata[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      avs_readdata <= UNMAPPED_DATA;
    end else if (avs_read && !ack) begin
      if (hit(avs_address, PIN_CTRL_ADDR)) begin
        avs_readdata <= {24'h000000,
                         {func, out_val, in_val, dur_cont, 1'b0}
                         & 8'hfe};
      end else if (hit(avs_address, IRQ_FLAGS_ADDR)) begin
        avs_readdata <= {28'h0000000, status[EV_NOISE:EV_HEADSET]};
      end else if (hit(avs_address, STATUS_ADDR)) begin
        avs_readdata <= {27'h0000000, status};
      end else if (hit(avs_address, MASK_ADDR)) begin
        avs_readdata <= {27'h0000000, mask};
      end else begin
        avs_readdata <= UNMAPPED_DATA;
      end
    end
  end

  // ****************************************************
  // Input sampling
  // ****************************************************
  // Sample only while the pin is an input, so a driven level never loops
  assign is_input = (func == FN_GP_IN) ||
                    (func >= FN_MIC_LO && func <= FN_MIC_HI) ||
                    (func == FN_BIT_CLK && !bit_clk_master);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      in_val  <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      if (func == FN_GP_IN) begin
        in_val <= pin_i; // [R4] [R5]
      end
      in_prev <= in_val;
    end
  end

  // Data taken on both clock edges, held in the system domain
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mic_prev      <= 1'b0;
      mic_data_rise <= 1'b0;
      mic_data_fall <= 1'b0;
    end else begin
      mic_prev <= mic_clk;
      if (func >= FN_MIC_LO && func <= FN_MIC_HI) begin
        if (mic_clk && !mic_prev) begin
          mic_data_rise <= pin_i; // [R8]
        end
        if (!mic_clk && mic_prev) begin
          mic_data_fall <= pin_i; // [R8]
        end
      end
    end
  end

  assign bit_clk_in = (func == FN_BIT_CLK && !bit_clk_master) ? pin_i
                                                                : 1'b0;

  // ****************************************************
  // Interrupt event selection
  // ****************************************************
  always_comb begin
    case (func)
      FN_HEADSET:   sel_event = headset_event; // [R3]
      FN_HS_BTN:    sel_event = headset_event | button_event; // [R10]
      FN_ALL4:      sel_event = headset_event | button_event |
                                short_event | noise_event; // [R11]
      FN_SC_NG:     sel_event = short_event | noise_event; // [R12]
      FN_HS_BTN_SC: sel_event = headset_event | button_event |
                                short_event; // [R13]
      FN_SHORT:     sel_event = short_event; // [R14]
      FN_NOISE:     sel_event = noise_event; // [R16]
      FN_BUTTON:    sel_event = button_event; // [R15]
      default:      sel_event = 1'b0;
    endcase
  end

  // ****************************************************
  // Pulse generator
  // ****************************************************
  // Events arriving during a pulse merge into it rather than queue
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= PS_IDLE;
      cnt   <= '0;
    end else begin
      case (state)
        PS_IDLE: begin
          if (sel_event) begin
            state <= PS_HIGH;
            cnt   <= (func == FN_HEADSET) ? CNT_W'(HEADSET_CNT - 1)
                                          : CNT_W'(PULSE_CNT - 1); // [R3] [R17]
          end
        end
        PS_HIGH: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (dur_cont && !pulse_hold) begin
            state <= PS_IDLE;
          end else if (dur_cont) begin
            state <= PS_GAP;
            cnt   <= CNT_W'(GAP_CNT - 1);
          end else begin
            state <= PS_IDLE;
          end
        end
        PS_GAP: begin
          if (!pulse_hold) begin
            state <= PS_IDLE; // [R18]
          end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= PS_HIGH;
            cnt   <= CNT_W'(PULSE_CNT - 1); // [R18]
          end
        end
        default: state <= PS_IDLE;
      endcase
    end
  end

  // Repeat request stands until the host reads the flags; a new event wins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pulse_hold <= 1'b0;
    end else if (sel_event) begin
      pulse_hold <= 1'b1;
    end else if (flags_read || !dur_cont) begin
      pulse_hold <= 1'b0; // [R18]
    end
  end

  assign sel_level = (state == PS_HIGH);

  // ****************************************************
  // Pin drive
  // ****************************************************
  always_comb begin
    pin_o  = 1'b0;
    pin_oe = 1'b0; // [R1]
    case (func)
      FN_GP_OUT: begin
        pin_o  = out_val; // [R6] [R7]
        pin_oe = 1'b1;
      end
      FN_BIT_CLK: begin
        pin_o  = bit_clk_master & bit_clk_out; // [R9]
        pin_oe = bit_clk_master;
      end
      FN_HEADSET, FN_HS_BTN, FN_ALL4, FN_SC_NG, FN_HS_BTN_SC, FN_SHORT,
      FN_NOISE, FN_BUTTON: begin
        pin_o  = sel_level;
        pin_oe = 1'b1;
      end
      default: begin
        pin_o  = 1'b0; // [R2] [R4] [R8]
        pin_oe = 1'b0;
      end
    endcase
  end

  // ****************************************************
  // Sticky status and interrupt
  // ****************************************************
  assign ev_set = {is_input && func == FN_GP_IN && (in_val != in_prev),
                   noise_event, short_event, button_event, headset_event};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      status <= '0;
    end else if (avs_write && ack && avs_byteenable[0] &&
                 hit(avs_address, STATUS_ADDR)) begin
      status <= (status & ~avs_writedata[EV_W-1:0]) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  assign irq = |(status & mask);

endmodule : mpt_pin_two

// ### tb/mpt_pin_host.sv
`timescale 1ns/100ps
// ****
// Host logic on the pin
// ****
module mpt_pin_host (
  // Block side
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Host side
  input  wire logic drive_en,
  input  wire logic drive_lvl,
  output logic      pin_i
);
  // Pull-up holds the line high while nobody drives it
  assign pin_i = pin_oe ? pin_o : (drive_en ? drive_lvl : 1'b1);
endmodule : mpt_pin_host

// ### tb/mpt_pin_two_chk.sv
`timescale 1ns/100ps
// ****
// Pin checker
// ****
module mpt_pin_two_chk
  import mpt_pkg::*;
#(
  parameter int HEADSET_CNT = 20,
  parameter int PULSE_CNT   = 24,
  parameter int GAP_CNT     = 10
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        headset_event,
  input wire logic        button_event,
  input wire logic        short_event,
  input wire logic        noise_event,
  input wire logic        bit_clk_master,
  input wire logic        bit_clk_out,
  input wire logic        pin_i,
  input wire logic        pin_o,
  input wire logic        pin_oe,
  input wire logic        irq
);
  logic [3:0] func_q;
  logic       out_q;
  logic       dur_q;
  logic       pin_q;
  int         hcnt;
  wire ev_any = headset_event | button_event | short_event | noise_event
                | (pin_i ^ pin_q);
  wire irq_fn = func_q == FN_HEADSET || func_q >= FN_HS_BTN;
  wire [31:0] lim = func_q == FN_HEADSET ? HEADSET_CNT : PULSE_CNT;
  // Shadow of the control register, taken at the accepting edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      func_q <= 4'h0;
      out_q  <= 1'b0;
      dur_q  <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                 && avs_address == PIN_CTRL_ADDR) begin
      func_q <= avs_writedata[7:4];
      out_q  <= avs_writedata[3];
      dur_q  <= avs_writedata[1];
    end
  end
  always_ff @(posedge sys_clk) begin
    pin_q <= pin_i;
    hcnt  <= (nrst && pin_o && irq_fn) ? hcnt + 1 : 0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest; endsequence
  sequence s_evt; func_q == FN_SHORT && short_event && !pin_o; endsequence
  property p_off; func_q == FN_OFF |-> !pin_oe; endproperty
  property p_gpin; func_q == FN_GP_IN |-> !pin_oe; endproperty
  property p_gpout; func_q == FN_GP_OUT |-> pin_oe && pin_o == out_q;
  endproperty
  property p_mic; func_q >= FN_MIC_LO && func_q <= FN_MIC_HI |-> !pin_oe;
  endproperty
  property p_bclk; func_q == FN_BIT_CLK |-> pin_oe == bit_clk_master
    && (!bit_clk_master || pin_o == bit_clk_out); endproperty
  property p_ack; s_req |=> s_ack; endproperty
  property p_start; s_evt |=> pin_o [*8]; endproperty
  property p_len; irq_fn && !dur_q |-> hcnt <= lim; endproperty
  property p_irq; $rose(irq) |-> $past(ev_any) || $past(ev_any, 2)
    || $past(ev_any, 3) || $past(avs_write); endproperty
  a_off: assert property (p_off) else $error("pin driven while off");
  a_gpin: assert property (p_gpin) else $error("input driven");
  a_gpout: assert property (p_gpout) else $error("output level");
  a_mic: assert property (p_mic) else $error("mic pin driven");
  a_bclk: assert property (p_bclk) else $error("bit clock pin");
  a_ack: assert property (p_ack) else $error("bus answer late");
  a_start: assert property (p_start) else $error("pulse start");
  a_len: assert property (p_len) else $error("pulse too long");
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : mpt_pin_two_chk

bind mpt_pin_two mpt_pin_two_chk #(.HEADSET_CNT(HEADSET_CNT),
  .PULSE_CNT(PULSE_CNT), .GAP_CNT(GAP_CNT)) mpt_pin_two_chk_i (.sys_clk,
  .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .headset_event, .button_event,
  .short_event, .noise_event, .bit_clk_master, .bit_clk_out, .pin_i,
  .pin_o, .pin_oe, .irq);

// ### tb/test_mpt_pin_two.sv
`timescale 1ns/100ps
module test_mpt_pin_two;
  import mpt_pkg::*;
  localparam int HS = 20;
  localparam int PC = 24;
  localparam int GC = 10;
  logic        sys_clk = 0;
  logic        nrst = 0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic [3:0]  ev = 4'h0;
  logic        bc_m = 0;
  logic        bc_o = 0;
  logic        mic_clk = 0;
  logic        drv_en = 0;
  logic        drv_lvl = 0;
  logic        avs_waitrequest, bit_clk_in, mic_data_rise, mic_data_fall;
  logic        pin_i, pin_o, pin_oe, irq;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  mpt_pin_two #(.HEADSET_CNT(HS), .PULSE_CNT(PC), .GAP_CNT(GC))
  mpt_pin_two_i (.sys_clk(sys_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .headset_event(ev[0]), .button_event(ev[1]), .short_event(ev[2]),
    .noise_event(ev[3]), .bit_clk_master(bc_m), .bit_clk_out(bc_o),
    .bit_clk_in(bit_clk_in), .mic_clk(mic_clk),
    .mic_data_rise(mic_data_rise), .mic_data_fall(mic_data_fall),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .irq(irq));
  mpt_pin_host mpt_pin_host_i (.pin_o(pin_o), .pin_oe(pin_oe),
    .drive_en(drv_en), .drive_lvl(drv_lvl), .pin_i(pin_i));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Request held until waitrequest is seen low, then released
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [7:0] d);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic pulse(input int i);
    ev <= 4'h1 << i;
    @(posedge sys_clk);
    ev <= 4'h0;
  endtask : pulse
  function automatic logic [3:0] sel(input logic [3:0] c);
    case (c)
      4'h2: return 4'h1;
      4'h9: return 4'h3;
      4'ha: return 4'hf;
      4'hb: return 4'hc;
      4'hc: return 4'h7;
      4'hd: return 4'h4;
      4'he: return 4'h8;
      default: return 4'h2;
    endcase
  endfunction : sel
  task automatic t_basic;
    bus(0, PIN_CTRL_ADDR, 8'h00);
    chk(q, {24'h0, CTRL_RESET});
    bus(1, PIN_CTRL_ADDR, 8'h48);
    chk({pin_oe, pin_o}, 2'b11);
    bus(0, PIN_CTRL_ADDR, 8'h00);
    chk(q, 32'h48);
    // Read data still holds the control value, so a zero here means decode
    bus(0, 10'h3fc, 8'h00);
    chk(q, UNMAPPED_DATA);
    bus(1, PIN_CTRL_ADDR, 8'h40);
    chk({pin_oe, pin_o}, 2'b10);
    drv_en  <= 1'b1;
    drv_lvl <= 1'b1;
    bus(1, PIN_CTRL_ADDR, 8'h30);
    bus(0, PIN_CTRL_ADDR, 8'h00);
    chk({pin_oe, q[7:0]}, 9'h034);
    drv_lvl <= 1'b0;
    // The input bit lags the pin by one edge
    @(posedge sys_clk);
    bus(0, PIN_CTRL_ADDR, 8'h00);
    chk(q[7:0], 8'h30);
    $display("basic test done");
  endtask : t_basic
  // Each event must reach the pin only through its selected codes
  task automatic t_intr;
    logic [3:0] m;
    for (int c = 2; c < 16; c++) if (c == 2 || c > 8) begin
      bus(1, PIN_CTRL_ADDR, {c[3:0], 4'h0});
      m = sel(c[3:0]);
      for (int e = 0; e < 4; e++) begin
        pulse(e);
        @(negedge sys_clk);
        chk({pin_oe, pin_o}, {1'b1, m[e]});
        if (m[e]) begin
          repeat ((c == 2 ? HS : PC) - 1) @(negedge sys_clk);
          chk(pin_o, 1'b1);
          @(negedge sys_clk);
          chk(pin_o, 1'b0);
        end
        @(posedge sys_clk);
      end
    end
    $display("interrupt test done");
  endtask : t_intr
  task automatic t_cont;
    bus(1, PIN_CTRL_ADDR, 8'hd2);
    pulse(2);
    repeat (PC + GC + 4) @(negedge sys_clk);
    chk(pin_o, 1'b1);
    @(posedge sys_clk);
    bus(0, IRQ_FLAGS_ADDR, 8'h00);
    chk(q[3:0], 4'hf);
    repeat (PC) @(posedge sys_clk);
    repeat (2 * (PC + GC)) begin
      @(negedge sys_clk);
      chk(pin_o, 1'b0);
    end
    @(posedge sys_clk);
    bus(1, PIN_CTRL_ADDR, 8'h00);
    $display("continuous test done");
  endtask : t_cont
  task automatic t_irq;
    bus(1, STATUS_ADDR, 8'h1f);
    bus(1, MASK_ADDR, 8'h01);
    pulse(1);
    @(posedge sys_clk);
    chk(irq, 1'b0);
    pulse(0);
    @(posedge sys_clk);
    chk(irq, 1'b1);
    bus(0, STATUS_ADDR, 8'h00);
    chk(q[7:0], 8'h03);
    bus(1, MASK_ADDR, 8'h00);
    chk(irq, 1'b0);
    bus(1, MASK_ADDR, 8'h01);
    chk(irq, 1'b1);
    bus(1, STATUS_ADDR, 8'h01);
    chk(irq, 1'b0);
    $display("irq test done");
  endtask : t_irq
  task automatic t_pins;
    bus(1, PIN_CTRL_ADDR, 8'h80);
    bc_m <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bc_o <= i[0];
      @(negedge sys_clk);
      chk({pin_oe, pin_o}, {1'b1, i[0]});
      @(posedge sys_clk);
    end
    bc_m    <= 1'b0;
    drv_lvl <= 1'b1;
    @(negedge sys_clk);
    chk({pin_oe, bit_clk_in}, 2'b01);
    @(posedge sys_clk);
    for (int c = 5; c < 8; c++) begin
      bus(1, PIN_CTRL_ADDR, {c[3:0], 4'h0});
      // Opposite levels at rise and fall tell the two samplers apart
      repeat (4) begin
        drv_lvl <= mic_clk ? !c[0] : c[0];
        mic_clk <= ~mic_clk;
        repeat (4) @(posedge sys_clk);
      end
      chk({pin_oe, mic_data_rise, mic_data_fall}, {1'b0, c[0], !c[0]});
    end
    $display("pin mode test done");
  endtask : t_pins
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_basic();
    t_intr();
    t_cont();
    t_irq();
    t_pins();
    complete_run();
  end
endmodule : test_mpt_pin_two
